// [design/radio_sm_pkg.sv]
// Shared constants and types for the radio control configuration block
package radio_sm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [5:0] ADDR_RADIO_SM_CONFIG_ZERO = 6'h18;
  localparam int AUTOCAL_LSB = 4;
  localparam int POTIME_LSB = 2;
  localparam logic [1:0] AUTOCAL_RESET = 2'h0;
  localparam logic [1:0] POTIME_RESET = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Autocalibration modes
  localparam logic [1:0] AUTOCAL_NEVER = 2'h0;
  localparam logic [1:0] AUTOCAL_IDLE_TO_TX = 2'h1;
  localparam logic [1:0] AUTOCAL_TX_TO_IDLE = 2'h2;
  localparam logic [1:0] AUTOCAL_EVERY_4TH = 2'h3;
  localparam logic [1:0] QUAD_LAST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on timeout, in ripple counter expiries
  localparam int EXP_CNT_W = 9;
  localparam logic [8:0] EXPIRY_SEL0 = 9'h001;
  localparam logic [8:0] EXPIRY_SEL1 = 9'h010;
  localparam logic [8:0] EXPIRY_SEL2 = 9'h040;
  localparam logic [8:0] EXPIRY_SEL3 = 9'h100;
  localparam int RIPPLE_BITS_DEF = 6;

  typedef struct packed {
    logic [1:0] synth_autocal_select;
    logic [1:0] poweron_timeout_select;
  } cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [2:0] {
    PWR_OFF = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_READY = 3'b100
  } pwr_state_e;

  function automatic logic [8:0] expiry_target(input logic [1:0] sel);
    case (sel)
      2'h0: expiry_target = EXPIRY_SEL0;
      2'h1: expiry_target = EXPIRY_SEL1;
      2'h2: expiry_target = EXPIRY_SEL2;
      default: expiry_target = EXPIRY_SEL3;
    endcase
  endfunction

  function automatic logic [7:0] pack_cfg(input cfg_s c);
    pack_cfg = {2'h0, c.synth_autocal_select, c.poweron_timeout_select, 2'h0};
  endfunction

endpackage

// [design/ripple_expiry.sv]
// Ripple counter, running only while i_run is high and cleared otherwise, that pulses once per full wrap
`timescale 1ns/100ps
module ripple_expiry #(
  parameter int BITS = 6
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  output logic o_expire
);

  logic [BITS-1:0] cnt_r;
  logic [BITS-1:0] cnt_nxt;
  logic expire_nxt;

  // Refused at elaboration, not at run time
  if (BITS < 1 || BITS > 16) begin : g_bits_chk
    $error("ripple_expiry: BITS out of range");
  end

  always_comb begin
    cnt_nxt = cnt_r;
    expire_nxt = 1'b0;
    if (i_run) begin
      cnt_nxt = cnt_r + BITS'(1);
      expire_nxt = &cnt_r;
    end else begin
      // Restart from zero so each start-up gets the full wait
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
      o_expire <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_expire <= expire_nxt;
    end
  end

endmodule

// [design/radio_sm_autocal_poweron_cfg.sv]
// Radio control configuration register, autocalibration and start-up wait
`timescale 1ns/100ps

// Notes on behaviour
// - Mode 00: calibrate only on calibrate strobe.
// - Mode 01: calibrate on idle to transmit.
// - Mode 10: calibrate on transmit to idle.
// - Mode 11: calibrate every fourth transmit-to-idle.
// - Wait 1/16/64/256 expiries, then ready low.
// - Timeout field survives sleep power-down.
module radio_sm_autocal_poweron_cfg #(
  parameter int RIPPLE_BITS = radio_sm_pkg::RIPPLE_BITS_DEF
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire radio_sm_pkg::reg_req_s i_reg_req,
  input wire logic i_calibrate_strobe,
  input wire logic i_idle_to_tx,
  input wire logic i_tx_to_idle,
  input wire logic i_xosc_stable,
  input wire logic i_sleep,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_synth_cal_start,
  output radio_sm_pkg::cfg_s o_cfg,
  output logic o_chip_ready_low
);
  import radio_sm_pkg::*;

  // Refused at elaboration, not at run time
  if (RIPPLE_BITS < 1 || RIPPLE_BITS > 16) begin : g_bits_chk
    $error("RIPPLE_BITS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic hit;
  cfg_s cfg_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;

  assign hit = (i_reg_req.addr == ADDR_RADIO_SM_CONFIG_ZERO);

  always_comb begin
    cfg_nxt = o_cfg;
    rdata_nxt = 8'h00;
    rvalid_nxt = i_reg_req.rd;
    // Sleep has no term here: settings stay put across power-down
    if (i_reg_req.wr && hit) begin
      // Only the two live fields take write data
      cfg_nxt.synth_autocal_select =
        i_reg_req.wdata[AUTOCAL_LSB +: 2];
      cfg_nxt.poweron_timeout_select =
        i_reg_req.wdata[POTIME_LSB +: 2];
    end
    if (i_reg_req.rd && hit) begin
      rdata_nxt = pack_cfg(o_cfg);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cfg.synth_autocal_select <= AUTOCAL_RESET;
      o_cfg.poweron_timeout_select <= POTIME_RESET;
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_cfg <= cfg_nxt;
      o_reg_rdata <= rdata_nxt;
      o_reg_rvalid <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer autocalibration
  logic [1:0] quad_r;
  logic [1:0] quad_nxt;
  logic cal_nxt;

  always_comb begin
    quad_nxt = quad_r;
    // Manual strobe works in every mode
    cal_nxt = i_calibrate_strobe;
    case (o_cfg.synth_autocal_select)
      AUTOCAL_NEVER: begin
        cal_nxt = i_calibrate_strobe;
      end
      AUTOCAL_IDLE_TO_TX: begin
        if (i_idle_to_tx) begin
          cal_nxt = 1'b1;
        end
      end
      AUTOCAL_TX_TO_IDLE: begin
        if (i_tx_to_idle) begin
          cal_nxt = 1'b1;
        end
      end
      AUTOCAL_EVERY_4TH: begin
        if (i_tx_to_idle) begin
          quad_nxt = quad_r + 2'h1;
          if (quad_r == QUAD_LAST) begin
            cal_nxt = 1'b1;
          end
        end
      end
      default: begin
        cal_nxt = i_calibrate_strobe;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      quad_r <= 2'h0;
      o_synth_cal_start <= 1'b0;
    end else begin
      quad_r <= quad_nxt;
      o_synth_cal_start <= cal_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up wait after the crystal settles
  pwr_state_e state_r;
  pwr_state_e state_nxt;
  logic [EXP_CNT_W-1:0] exp_r;
  logic [EXP_CNT_W-1:0] exp_nxt;
  logic rdy_low_nxt;
  logic expire;
  logic [EXP_CNT_W-1:0] target;

  assign target = expiry_target(o_cfg.poweron_timeout_select);

  ripple_expiry #(
    .BITS(RIPPLE_BITS)
  ) u_ripple (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(state_r == PWR_WAIT),
    .o_expire(expire)
  );

  always_comb begin
    state_nxt = state_r;
    exp_nxt = exp_r;
    rdy_low_nxt = o_chip_ready_low;
    case (state_r)
      PWR_OFF: begin
        exp_nxt = '0;
        rdy_low_nxt = 1'b1;
        if (i_xosc_stable && !i_sleep) begin
          state_nxt = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        if (expire) begin
          exp_nxt = exp_r + 9'h001;
          // Ready drops only after the chosen count of wraps
          if (exp_nxt >= target) begin
            state_nxt = PWR_READY;
            rdy_low_nxt = 1'b0;
          end
        end
      end
      PWR_READY: begin
        rdy_low_nxt = 1'b0;
      end
      default: begin
        state_nxt = PWR_OFF;
        rdy_low_nxt = 1'b1;
      end
    endcase
    // Sleep or a lost crystal restarts the wait from nothing
    if (i_sleep || !i_xosc_stable) begin
      state_nxt = PWR_OFF;
      exp_nxt = '0;
      rdy_low_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= PWR_OFF;
      exp_r <= '0;
      o_chip_ready_low <= 1'b1;
    end else begin
      state_r <= state_nxt;
      exp_r <= exp_nxt;
      o_chip_ready_low <= rdy_low_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_NEVER_AUTO: assert property (
    (o_cfg.synth_autocal_select == AUTOCAL_NEVER && !i_calibrate_strobe)
      |=> !o_synth_cal_start)
    else $error("autocal fired in manual mode");

  AST_IDLE_TX_CAL: assert property (
    (o_cfg.synth_autocal_select == AUTOCAL_IDLE_TO_TX && i_idle_to_tx)
      |=> o_synth_cal_start)
    else $error("no cal on idle to transmit");

  AST_TX_IDLE_CAL: assert property (
    (o_cfg.synth_autocal_select == AUTOCAL_TX_TO_IDLE && i_tx_to_idle)
      |=> o_synth_cal_start)
    else $error("no cal on transmit to idle");

  AST_FOURTH_CAL: assert property (
    (o_cfg.synth_autocal_select == AUTOCAL_EVERY_4TH && i_tx_to_idle
      && !i_calibrate_strobe)
      |=> (o_synth_cal_start == ($past(quad_r) == QUAD_LAST)))
    else $error("fourth-return cal wrong");

  AST_READY_AT_COUNT: assert property (
    (state_r == PWR_WAIT && expire && exp_r == target - 9'h001
      && !i_sleep && i_xosc_stable)
      |=> !o_chip_ready_low)
    else $error("ready not low at count");

  AST_READY_NOT_EARLY: assert property (
    (state_r == PWR_WAIT && !(expire && exp_r + 9'h001 >= target))
      |=> o_chip_ready_low)
    else $error("ready low too early");

  AST_SLEEP_KEEPS: assert property (
    (i_sleep && !(i_reg_req.wr && hit)) |=> $stable(o_cfg))
    else $error("config lost in sleep");

  AST_UNUSED_ZERO: assert property (
    (i_reg_req.rd && hit) |=>
      (o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[1:0] == 2'h0
       && o_reg_rvalid))
    else $error("unused bits not zero");

endmodule

// [dv/radio_sm_autocal_poweron_cfg_bench.sv]
// Self-checking bench for the radio control configuration block
`timescale 1ns/100ps
module radio_sm_autocal_poweron_cfg_bench;
  import radio_sm_pkg::*;
  // Short ripple counter keeps the start-up waits brief
  localparam int RB = 2;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_s req = '0;
  logic strobe = 1'b0;
  logic i2t = 1'b0;
  logic t2i = 1'b0;
  logic stable = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic cal;
  logic rdy_low;
  cfg_s cfg;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32'h57b5;
  int nexp[4] = '{1, 16, 64, 256};
  logic [8:0] rq[$];
  logic [8:0] cq[$];

  radio_sm_autocal_poweron_cfg #(.RIPPLE_BITS(RB)) i_dut (
    .i_clk(clk),
    .i_sys_rst(sys_rst),
    .i_reg_req(req),
    .i_calibrate_strobe(strobe),
    .i_idle_to_tx(i2t),
    .i_tx_to_idle(t2i),
    .i_xosc_stable(stable),
    .i_sleep(sleep),
    .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid),
    .o_synth_cal_start(cal),
    .o_cfg(cfg),
    .o_chip_ready_low(rdy_low)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [8:0] got, logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    tick();
    req <= '0;
    tick();
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] e);
    rq.push_back({1'b0, e});
    req <= '{1'b0, 1'b1, a, 8'h00};
    tick();
    req <= '0;
    tick();
  endtask

  // Order is strobe, idle-to-transmit, transmit-to-idle
  task automatic ev(logic [2:0] v, bit e);
    if (e) begin
      cq.push_back(9'h001);
    end
    {strobe, i2t, t2i} <= v;
    tick();
    {strobe, i2t, t2i} <= 3'h0;
    tick();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: each answer retires the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (rq.size() == 0) begin
        chk("rvalid", 9'h001, 9'h000);
      end else begin
        chk("rdata", {1'b0, rdata}, rq.pop_front());
      end
    end
    if (cal === 1'b1) begin
      if (cq.size() == 0) begin
        chk("cal_start", 9'h001, 9'h000);
      end else begin
        chk("cal_start", 9'h001, cq.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    int n;
    int lo;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    tick();
    chk("cfg", 9'(cfg), 9'h001);
    chk("ready_low", 9'(rdy_low), 9'h001);
    rd(6'h18, 8'h04);
    // Mode 11 first, while the transition count is still fresh
    wr(6'h18, 8'hF0);
    repeat (3) ev(3'b001, 1'b0);
    ev(3'b001, 1'b1);
    ev(3'b010, 1'b0);
    repeat (3) ev(3'b001, 1'b0);
    ev(3'b001, 1'b1);
    for (int m = 0; m < 3; m++) begin
      d = 8'($random(seed));
      d[5:4] = m[1:0];
      wr(6'h18, d);
      chk("cfg", 9'({m[1:0], d[3:2]}), 9'(cfg));
      rd(6'h18, d & 8'h3C);
      ev(3'b100, 1'b1);
      ev(3'b010, m == 1);
      ev(3'b001, m == 2);
    end
    // Unmapped place: write ignored, read answers zero
    wr(6'h19, 8'hFF);
    rd(6'h19, 8'h00);
    rd(6'h18, d & 8'h3C);
    for (int s = 0; s < 4; s++) begin
      wr(6'h18, {4'h0, s[1:0], 2'h0});
      stable <= 1'b1;
      n = 0;
      while (rdy_low !== 1'b0 && n < 2000) begin
        tick();
        n++;
      end
      // One wrap of the short counter lasts 2**RB cycles
      lo = nexp[s] * (1 << RB);
      chk("wait", 9'(n >= lo && n <= lo + 8), 9'h001);
      if (n >= 2000) begin
        stop_test();
      end
      sleep <= 1'b1;
      tick(2);
      chk("ready_low", 9'(rdy_low), 9'h001);
      rd(6'h18, {4'h0, s[1:0], 2'h0});
      sleep <= 1'b0;
      stable <= 1'b0;
      tick(2);
    end
    tick(4);
    chk("cal_left", 9'(cq.size()), 9'h000);
    chk("rd_left", 9'(rq.size()), 9'h000);
    stop_test();
  end
endmodule
